// ---- bench/tb_ustx_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ustx_top
  import ustx_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, serial_out_pin, serial_out_oe, serial_in_pin, serial_in_owned;
  logic        irq_tx_empty, irq_tx_complete, irq_tx_complete_ack;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, got_resp;
  int          fails, tests_run;
  localparam logic [31:0] TXE = 32'h1 << B_TX_EN;
  localparam logic [31:0] RXE = 32'h1 << B_RX_EN;
  localparam logic [31:0] EIE = 32'h1 << B_EMPTY_IE;
  localparam logic [31:0] CIE = 32'h1 << B_CMPL_IE;
  ustx_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_out_pin, .serial_out_oe, .serial_in_pin,
    .serial_in_owned, .irq_tx_empty, .irq_tx_complete, .irq_tx_complete_ack
  );
  ustx_peer #(.BIT_CYC(16)) peer (.aclk, .line_in(serial_out_pin), .line_out(serial_in_pin));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chkw
  task automatic chkb(input logic g, input logic e);
    chkw({31'h0, g}, {31'h0, e});
  endtask : chkb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= {28'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    got_resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr  <= {28'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    got_data = s_axi_rdata;
    got_resp = s_axi_rresp;
  endtask : rd
  // f is {size code, parity on, odd, two stops}; divisor is taken from b
  task automatic cfg(input logic [5:0] f, input logic [31:0] b);
    wr(ADDR_CTRL_C, {26'h0, f[2:0], f[4:3], 1'b0});
    wr(ADDR_CTRL_B, b | {29'h0, f[5], 2'h0});
  endtask : cfg
  function automatic logic [15:0] frame(logic [8:0] d, int nb, logic pe, logic od);
    logic [15:0] f;
    logic        p;
    f = 16'hFFFF;
    p = od;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      f[i + 1] = d[i];
      p ^= d[i];
    end
    if (pe)
      f[nb + 1] = p;
    return f;
  endfunction : frame
  task automatic t_reset();
    chkb(serial_out_pin, 1'b1);
    chkb(serial_out_oe, 1'b0);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'hE0, 32'h20);
    rd(ADDR_CTRL_C);
    chkw(got_data & 32'h3E, 32'h06);
    wr(4'h6, 32'h0);
    chkw({30'h0, got_resp}, {30'h0, AXI_SLVERR});
    rd(4'h6);
    chkw({30'h0, got_resp}, {30'h0, AXI_SLVERR});
    chkw(got_data, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_formats();
    logic [5:0]  fmt [4];
    logic [15:0] got, m;
    int          nb, len;
    fmt = '{6'h00, 6'h16, 6'h1D, 6'h3E};
    foreach (fmt[k])
    begin
      nb  = (fmt[k][5:3] == SIZE_CODE_NINE) ? 9 : int'(fmt[k][5:3]) + 5;
      len = 2 + nb + int'(fmt[k][2]) + int'(fmt[k][0]);
      m   = 16'hFFFF >> (16 - len);
      cfg(fmt[k], TXE | 32'h1);
      fork
        wr(ADDR_DATA, 32'h1A5);
        peer.catch(len, got);
      join
      chkw({16'h0, got & m}, {16'h0, frame(9'h1A5, nb, fmt[k][2], fmt[k][1]) & m});
      chkb(serial_out_oe, 1'b1);
    end
    // double speed with divisor one still gives the peer its sixteen-cycle bit
    wr(ADDR_STAT_A, 32'h1 << A_DOUBLE_SPEED);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'h2, 32'h2);
    cfg(6'h18, TXE | (32'h1 << B_DIV_LSB));
    fork
      wr(ADDR_DATA, 32'h5A);
      peer.catch(10, got);
    join
    chkw({16'h0, got & 16'h3FF}, {16'h0, frame(9'h05A, 8, 1'b0, 1'b0) & 16'h3FF});
    wr(ADDR_STAT_A, 32'h0);
    $display("format test done");
  endtask : t_formats
  task automatic t_flags();
    int n;
    n = 0;
    cfg(6'h18, TXE | EIE | CIE);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'h60, 32'h60);
    wr(ADDR_STAT_A, 32'h40);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'h60, 32'h20);
    wr(ADDR_DATA, 32'h11);
    wr(ADDR_DATA, 32'h22);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'h60, 32'h00);
    chkb(irq_tx_empty, 1'b0);
    // both frames back to back take 320 cycles; one alone would end near 150
    while (irq_tx_complete !== 1'b1 && n < 1000)
    begin
      @(posedge aclk);
      n++;
    end
    chkb(n > 250 && n < 1000, 1'b1);
    chkb(irq_tx_empty, 1'b1);
    irq_tx_complete_ack <= 1'b1;
    @(posedge aclk);
    irq_tx_complete_ack <= 1'b0;
    @(posedge aclk);
    chkb(irq_tx_complete, 1'b0);
    $display("flag test done");
  endtask : t_flags
  task automatic t_disable();
    logic [15:0] got;
    cfg(6'h18, TXE);
    fork
      begin
        wr(ADDR_DATA, 32'h3C);
        wr(ADDR_CTRL_B, 32'h0);
        chkb(serial_out_oe, 1'b1);
      end
      peer.catch(10, got);
    join
    chkw({16'h0, got & 16'h3FF}, {16'h0, frame(9'h03C, 8, 1'b0, 1'b0) & 16'h3FF});
    chkb(serial_out_oe, 1'b0);
    $display("disable test done");
  endtask : t_disable
  task automatic t_rx();
    cfg(6'h05, RXE);
    chkb(serial_in_owned, 1'b1);
    // a glitch shorter than half a bit must not open a frame
    peer.line_out <= 1'b0;
    repeat (3) @(posedge aclk);
    peer.line_out <= 1'b1;
    repeat (40) @(posedge aclk);
    peer.send(frame(9'h1FB, 5, 1'b1, 1'b0), 9);
    peer.send(frame(9'h004, 5, 1'b1, 1'b0), 9);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'h80, 32'h80);
    rd(ADDR_DATA);
    chkw(got_data, 32'h1B);
    rd(ADDR_DATA);
    chkw(got_data, 32'h04);
    rd(ADDR_STAT_A);
    chkw(got_data & 32'h80, 32'h00);
    $display("receive test done");
  endtask : t_rx
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    irq_tx_complete_ack = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_formats();
    t_flags();
    t_disable();
    t_rx();
    report_and_stop();
  end
  // the whole run needs about 2000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    report_and_stop();
  end
endmodule : tb_ustx_top
bind ustx_top ustx_top_asserts chk_i (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .serial_out_pin, .serial_out_oe, .irq_tx_complete,
  .irq_tx_complete_ack
);
`default_nettype wire

// ---- bench/ustx_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module ustx_peer #(
  parameter int BIT_CYC = 16
)(
  // clock
  input  wire logic aclk,
  // serial lines
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // frame vector carries start low, data lsb first, parity, stops high
  task automatic send(input logic [15:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_out <= f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask : send
  // samples mid-bit so a one-cycle skew of the sender is tolerated
  task automatic catch(input int n, output logic [15:0] f);
    int t;
    f = 16'h0;
    t = 0;
    while (line_in !== 1'b0 && t < 3000)
    begin
      @(posedge aclk);
      t++;
    end
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = line_in;
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask : catch
endmodule : ustx_peer
`default_nettype wire

// ---- bench/ustx_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ustx_top_asserts
  import ustx_pkg::*;
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // register bus
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // serial side
  input wire logic       serial_out_pin,
  input wire logic       serial_out_oe,
  input wire logic       irq_tx_complete,
  input wire logic       irq_tx_complete_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a stop bit lasts eight cycles at least, even at double speed with divisor zero
  logic [3:0] hi_cnt_q;
  always_ff @(posedge aclk)
    if (!aresetn || !serial_out_pin)
      hi_cnt_q <= 4'h0;
    else if (hi_cnt_q != 4'hF)
      hi_cnt_q <= hi_cnt_q + 4'h1;
  a_reset_idle: assert property (
    $rose(aresetn) |-> serial_out_pin && !serial_out_oe && !s_axi_bvalid && !s_axi_rvalid
  ) else $error("outputs not idle after reset");
  a_bit_min_len: assert property (
    $changed(serial_out_pin) && serial_out_oe |=> $stable(serial_out_pin)[*7]
  ) else $error("serial bit shorter than eight cycles");
  a_ar_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
  ) else $error("read answer late");
  a_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready
  ) else $error("read address taken while answer pending");
  a_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
  ) else $error("write answer not released");
  a_bresp_legal: assert property (
    s_axi_bvalid |-> (s_axi_bresp == AXI_OKAY || s_axi_bresp == AXI_SLVERR)
  ) else $error("bad write response code");
  a_cmpl_rise: assert property (
    $rose(irq_tx_complete) |-> serial_out_pin && hi_cnt_q >= 4'h7
  ) else $error("complete raised before stop bit ended");
  a_ack_clear: assert property (
    irq_tx_complete && irq_tx_complete_ack |=> !irq_tx_complete
  ) else $error("complete not cleared by service");
  a_oe_release: assert property (
    $fell(serial_out_oe) |-> hi_cnt_q >= 4'h7
  ) else $error("pin released inside a frame");
  c_cmpl: cover property ($rose(irq_tx_complete));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == AXI_SLVERR);
  c_release: cover property ($fell(serial_out_oe));
endmodule : ustx_top_asserts
`default_nettype wire

// ---- design/ustx_rxbuf.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-entry receive buffer; head comes out of a register
module ustx_rxbuf
  import ustx_pkg::*;
#(
  parameter int WIDTH = 9
)(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic             rd_en,
  input  wire logic             flush,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  not_empty,
  output logic                  full
);
  typedef struct packed {
    logic [WIDTH-1:0] e0;
    logic [WIDTH-1:0] e1;
    logic [1:0]       cnt;
  } ustx_rxb_t;
  ustx_rxb_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    if (rd_en && s_q.cnt != 2'h0)
    begin
      s_d.e0  = s_q.e1;
      s_d.cnt = s_q.cnt - 2'h1;
    end
    if (wr_en && s_d.cnt != 2'(RX_DEPTH))
    begin
      if (s_d.cnt == 2'h0)
        s_d.e0 = wr_data;
      else
        s_d.e1 = wr_data;
      s_d.cnt = s_d.cnt + 2'h1;
    end
    if (flush)
      s_d.cnt = 2'h0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rd_data   = s_q.e0;
  assign not_empty = s_q.cnt != 2'h0;
  assign full      = s_q.cnt == 2'(RX_DEPTH);
endmodule : ustx_rxbuf
`default_nettype wire

// ---- design/ustx_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ustx_top
  import ustx_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial pins and port fallback
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_in_owned,
  // interrupt requests
  output logic             irq_tx_empty,
  output logic             irq_tx_complete,
  input  wire logic        irq_tx_complete_ack
);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
    TX_PAR  = 3'b010, TX_STOP  = 3'b110
  } ustx_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_PAR  = 3'b010, RX_STOP  = 3'b110
  } ustx_rx_st_t;

  typedef struct packed {
    logic              aw_ok;  logic [ADDR_W-1:0] aw_a;
    logic              w_ok;   logic [31:0]       w_d;  logic [3:0] w_s;
    logic              bvalid; logic [1:0]        bresp;
    logic              rvalid; logic [1:0]        rresp; logic [31:0] rdata;
    logic [7:0]        ctrl_b; logic [DIV_W-1:0]  div;   logic dbl;
    logic [2:0]        size;   logic stop2; logic par_en; logic par_odd;
    logic [DIV_W-1:0]  bcnt;
    logic [8:0]        tbuf;   logic tbuf_full; logic tx_cmpl; logic tx_act;
    ustx_tx_st_t       tst;    logic [3:0] tovs; logic [8:0] tsh;
    logic [3:0]        tbit;   logic tpar; logic tstop2;
    logic              tout;   logic toe;  logic irq_e; logic irq_c;
    logic              aw_rdy; logic w_rdy; logic ar_rdy;
    ustx_rx_st_t       rst;    logic [3:0] rovs; logic [8:0] rsh;
    logic [3:0]        rbit;   logic rpar; logic rxd_q;
  } ustx_state_t;
  ustx_state_t s_q, s_d;

  logic       tick;
  logic [3:0] ovs_top;
  logic [3:0] nbits;
  logic       rb_wr;
  logic       rb_rd;
  logic [8:0] rb_wdata;
  logic [8:0] rb_head;
  logic       rb_ne;
  logic       wr_go;
  logic       rd_go;

  assign ovs_top = s_q.dbl ? OVS_DOUBLE : OVS_NORMAL;
  assign nbits   = (s_q.size == SIZE_CODE_NINE) ? 4'h9 : {1'b0, s_q.size} + 4'h5;
  assign tick    = (s_q.bcnt == '0);
  assign wr_go   = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
  assign rd_go   = s_axi_arvalid && !s_q.rvalid;
  assign rb_rd   = rd_go && (s_axi_araddr[ADDR_W-1:0] == ADDR_DATA);

  ustx_rxbuf #(.WIDTH(9)) u_rxbuf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (rb_wr),
    .wr_data   (rb_wdata),
    .rd_en     (rb_rd),
    .flush     (!s_q.ctrl_b[B_RX_EN]),
    .rd_data   (rb_head),
    .not_empty (rb_ne),
    .full      ()
  );

  always_comb
  begin
    s_d      = s_q;
    rb_wr    = 1'b0;
    rb_wdata = s_q.rsh;
    // bus channels: address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_ok)
    begin
      s_d.aw_ok = 1'b1;
      s_d.aw_a  = s_axi_awaddr[ADDR_W-1:0];
    end
    if (s_axi_wvalid && !s_q.w_ok)
    begin
      s_d.w_ok = 1'b1;
      s_d.w_d  = s_axi_wdata;
      s_d.w_s  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    // baud down-counter
    s_d.bcnt = tick ? s_q.div : s_q.bcnt - 1'b1;
    // transmit shifter
    if (tick)
    begin
      s_d.tovs = s_q.tovs - 4'h1;
      if (s_q.tovs == 4'h0)
      begin
        s_d.tovs = ovs_top;
        case (s_q.tst)
          TX_START:
          begin
            s_d.tout = s_q.tsh[0];
            s_d.tsh  = {1'b0, s_q.tsh[8:1]};
            s_d.tbit = 4'h1;
            s_d.tst  = TX_DATA;
          end
          TX_DATA:
          begin
            if (s_q.tbit == nbits)
            begin
              if (s_q.par_en)
              begin
                s_d.tout = s_q.tpar;
                s_d.tst  = TX_PAR;
              end
              else
              begin
                s_d.tout = 1'b1;
                s_d.tst  = TX_STOP;
              end
            end
            else
            begin
              s_d.tout = s_q.tsh[0];
              s_d.tsh  = {1'b0, s_q.tsh[8:1]};
              s_d.tbit = s_q.tbit + 4'h1;
            end
          end
          TX_PAR:
          begin
            s_d.tout = 1'b1;
            s_d.tst  = TX_STOP;
          end
          TX_STOP:
          begin
            if (s_q.tstop2)
              s_d.tstop2 = 1'b0;
            else
              s_d.tst = TX_IDLE;
          end
          default:
            s_d.tst = TX_IDLE;
        endcase
      end
    end
    s_d.tx_act = (s_d.tst != TX_IDLE);
    if (s_d.tst == TX_IDLE && s_q.tbuf_full)
    begin
      // load shifter; mask by character size, ninth bit kept only for 9-bit
      s_d.tsh       = s_q.tbuf & ((9'h1 << nbits) - 9'h1);
      s_d.tpar      = ^s_d.tsh ^ s_q.par_odd;
      s_d.tstop2    = s_q.stop2;
      s_d.tbuf_full = 1'b0;
      s_d.tout      = 1'b0;
      s_d.tst       = TX_START;
      s_d.tovs      = ovs_top;
      s_d.tx_act    = 1'b1;
    end
    else if (s_q.tx_act && !s_d.tx_act)
      s_d.tx_cmpl = 1'b1;
    // pin ownership lingers until all pending data has gone
    if (s_q.ctrl_b[B_TX_EN])
      s_d.toe = 1'b1;
    else if (!s_q.tbuf_full && s_q.tst == TX_IDLE)
      s_d.toe = 1'b0;
    if (!s_d.toe)
      s_d.tout = 1'b1;
    // receiver
    s_d.rxd_q = serial_in_pin;
    if (!s_q.ctrl_b[B_RX_EN])
      s_d.rst = RX_IDLE;
    else if (tick)
    begin
      s_d.rovs = s_q.rovs - 4'h1;
      case (s_q.rst)
        RX_IDLE:
          if (!s_q.rxd_q)
          begin
            s_d.rst  = RX_START;
            s_d.rovs = {1'b0, ovs_top[3:1]};
          end
        RX_START:
          if (s_q.rovs == 4'h0)
          begin
            // mid-bit recheck rejects glitches
            s_d.rst  = s_q.rxd_q ? RX_IDLE : RX_DATA;
            s_d.rovs = ovs_top;
            s_d.rbit = 4'h0;
            s_d.rsh  = '0;
          end
        RX_DATA:
          if (s_q.rovs == 4'h0)
          begin
            s_d.rsh[s_q.rbit] = s_q.rxd_q;
            s_d.rbit = s_q.rbit + 4'h1;
            s_d.rovs = ovs_top;
            if (s_q.rbit + 4'h1 == nbits)
              s_d.rst = s_q.par_en ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (s_q.rovs == 4'h0)
          begin
            s_d.rpar = s_q.rxd_q ^ ^s_q.rsh ^ s_q.par_odd;
            s_d.rovs = ovs_top;
            s_d.rst  = RX_STOP;
          end
        RX_STOP:
          if (s_q.rovs == 4'h0)
          begin
            rb_wr   = 1'b1;
            s_d.rst = RX_IDLE;
          end
        default:
          s_d.rst = RX_IDLE;
      endcase
    end
    // register write
    if (wr_go)
    begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = AXI_OKAY;
      case (s_q.aw_a)
        ADDR_DATA:
          if (s_q.w_s[0])
          begin
            s_d.tbuf      = {s_q.ctrl_b[B_TX_NINTH], s_q.w_d[7:0]};
            s_d.tbuf_full = 1'b1;
          end
        ADDR_STAT_A:
          if (s_q.w_s[0])
          begin
            s_d.dbl = s_q.w_d[A_DOUBLE_SPEED];
            if (s_q.w_d[A_COMPLETE] && !(s_q.tx_act && !s_d.tx_act))
              s_d.tx_cmpl = 1'b0;
          end
        ADDR_CTRL_B:
        begin
          if (s_q.w_s[0])
          begin
            s_d.ctrl_b  = s_q.w_d[7:0];
            s_d.size[2] = s_q.w_d[B_SIZE_HI];
          end
          if (s_q.w_s[3])
            s_d.div[11:8] = s_q.w_d[27:24];
          if (s_q.w_s[2])
          begin
            s_d.div[7:0] = s_q.w_d[23:16];
            s_d.bcnt     = s_d.div;
          end
        end
        ADDR_CTRL_C:
          if (s_q.w_s[0])
          begin
            s_d.size[1:0] = s_q.w_d[C_SIZE_LSB +: 2];
            s_d.stop2     = s_q.w_d[C_STOP2];
            s_d.par_odd   = s_q.w_d[C_PAR_ODD];
            s_d.par_en    = s_q.w_d[C_PAR_EN];
          end
        default:
          s_d.bresp = AXI_SLVERR;
      endcase
    end
    // interrupt service acknowledge clears complete unless it sets now
    if (irq_tx_complete_ack && !(s_q.tx_act && !s_d.tx_act))
      s_d.tx_cmpl = 1'b0;
    // register read
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = AXI_OKAY;
      s_d.rdata  = '0;
      case (s_axi_araddr[ADDR_W-1:0])
        ADDR_DATA:
          s_d.rdata[7:0] = rb_head[7:0];
        ADDR_STAT_A:
        begin
          s_d.rdata[A_RX_COMPLETE]  = rb_ne;
          s_d.rdata[A_COMPLETE]     = s_q.tx_cmpl;
          s_d.rdata[A_EMPTY]        = !s_q.tbuf_full;
          s_d.rdata[A_DOUBLE_SPEED] = s_q.dbl;
        end
        ADDR_CTRL_B:
        begin
          s_d.rdata[7:0]                 = s_q.ctrl_b;
          s_d.rdata[B_RX_NINTH]          = rb_head[8];
          s_d.rdata[B_SIZE_HI]           = s_q.size[2];
          s_d.rdata[B_DIV_LSB +: DIV_W]  = s_q.div;
        end
        ADDR_CTRL_C:
        begin
          s_d.rdata[C_SIZE_LSB +: 2] = s_q.size[1:0];
          s_d.rdata[C_STOP2]         = s_q.stop2;
          s_d.rdata[C_PAR_ODD]       = s_q.par_odd;
          s_d.rdata[C_PAR_EN]        = s_q.par_en;
        end
        default:
          s_d.rresp = AXI_SLVERR;
      endcase
    end
    // outputs are registered copies of next state, so no output settles through logic
    s_d.aw_rdy = !s_d.aw_ok;
    s_d.w_rdy  = !s_d.w_ok;
    s_d.ar_rdy = !s_d.rvalid;
    s_d.irq_e  = s_d.ctrl_b[B_EMPTY_IE] && !s_d.tbuf_full;
    s_d.irq_c  = s_d.ctrl_b[B_CMPL_IE] && s_d.tx_cmpl;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q      <= '0;
      s_q.size <= SIZE_RESET;
      s_q.tout <= 1'b1;
      s_q.rxd_q <= 1'b1;
      s_q.tovs <= OVS_NORMAL;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // channel readies mirror the holding flags; one cycle per capture
  assign s_axi_awready   = s_q.aw_rdy;
  assign s_axi_wready    = s_q.w_rdy;
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_arready   = s_q.ar_rdy;
  assign s_axi_rvalid    = s_q.rvalid;
  assign s_axi_rresp     = s_q.rresp;
  assign s_axi_rdata     = s_q.rdata;
  assign serial_out_pin  = s_q.tout;
  assign serial_out_oe   = s_q.toe;
  assign serial_in_owned = s_q.ctrl_b[B_RX_EN];
  assign irq_tx_empty    = s_q.irq_e;
  assign irq_tx_complete = s_q.irq_c;
endmodule : ustx_top
`default_nettype wire

// ---- shared/ustx_pkg.sv ----
package ustx_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] ADDR_DATA   = 4'h0;
  localparam logic [3:0] ADDR_STAT_A = 4'h4;
  localparam logic [3:0] ADDR_CTRL_B = 4'h8;
  localparam logic [3:0] ADDR_CTRL_C = 4'hC;
  localparam int         ADDR_W      = 4;
  // serial_status_ctrl_b layout; the divisor sits in bits 27:16 of this register
  localparam int B_TX_NINTH     = 0;
  localparam int B_RX_NINTH     = 1;
  localparam int B_SIZE_HI      = 2;
  localparam int B_TX_EN        = 3;
  localparam int B_RX_EN        = 4;
  localparam int B_EMPTY_IE     = 5;
  localparam int B_CMPL_IE      = 6;
  localparam int B_RXC_IE       = 7;
  localparam int B_DIV_LSB      = 16;
  // serial_status_ctrl_a layout
  localparam int A_DOUBLE_SPEED = 1;
  localparam int A_EMPTY        = 5;
  localparam int A_COMPLETE     = 6;
  localparam int A_RX_COMPLETE  = 7;
  // serial_status_ctrl_c layout
  localparam int C_SIZE_LSB     = 1;
  localparam int C_STOP2        = 3;
  localparam int C_PAR_ODD      = 4;
  localparam int C_PAR_EN       = 5;
  localparam logic [2:0] SIZE_CODE_NINE = 3'h7;
  localparam logic [2:0] SIZE_RESET     = 3'h3;
  localparam int         DIV_W          = 12;
  localparam logic [3:0] OVS_NORMAL     = 4'hF;
  localparam logic [3:0] OVS_DOUBLE     = 4'h7;
  localparam logic [1:0] AXI_OKAY       = 2'h0;
  localparam logic [1:0] AXI_SLVERR     = 2'h2;
  localparam int         RX_DEPTH       = 2;
endpackage : ustx_pkg
